// ==== src/tape_punch_pkg.sv ====
// Constants, command codes and carrier types for the tape punch I/O device.
// Assumes a 25 MHz system clock and an APB master carrying the I/O bus commands.
package tape_punch_pkg;

	localparam int CLK_HZ          = 25_000_000;
	localparam int ADDR_W          = 11;
	localparam int DATA_W          = 32;
	localparam int DEV_W           = 7;
	localparam int DEV_LSB         = 4;
	localparam int CMD_LSB         = 2;
	localparam logic [DEV_W-1:0] PUNCH_DEV_NUM  = 7'h40;
	localparam logic [DEV_W-1:0] STATUS_DEV_NUM = 7'h41;

	// Control word, low bit is the word's bit 35
	localparam int CHAN_LSB        = 0;
	localparam int CHAN_W          = 3;
	localparam int DONE_BIT        = 3;
	localparam int BUSY_BIT        = 4;
	localparam int MODE_BIT        = 5;
	localparam int CTRL_W          = 6;
	localparam int NUM_CHAN        = 7;
	localparam logic [CHAN_W-1:0] CHAN_NONE = 3'h0;

	localparam int PDATA_W         = 8;
	localparam int BIN_W           = 6;
	localparam int HOLE7_BIT       = 6;
	localparam int HOLE8_BIT       = 7;

	localparam int ST_MOTOR_ON     = 0;
	localparam int ST_MOTOR_READY  = 1;
	localparam int ST_PUNCHING     = 2;

	// Timing
	localparam int TMR_W           = 27;
	localparam int SPINUP_MS       = 1000;
	localparam int IDLE_MS         = 5000;
	localparam int LINE_RATE_X10   = 633;
	localparam int SPINUP_CYC_INT  = (CLK_HZ / 1000) * SPINUP_MS;
	localparam int IDLE_CYC_INT    = (CLK_HZ / 1000) * IDLE_MS;
	localparam int LINE_CYC_INT    = (CLK_HZ * 10) / LINE_RATE_X10;
	localparam logic [TMR_W-1:0] SPINUP_CYC = TMR_W'(SPINUP_CYC_INT);
	localparam logic [TMR_W-1:0] IDLE_CYC   = TMR_W'(IDLE_CYC_INT);
	localparam logic [TMR_W-1:0] LINE_CYC   = TMR_W'(LINE_CYC_INT);

	typedef enum logic [1:0] {
		CMD_LOAD_CONTROL,
		CMD_READ_CONDITIONS,
		CMD_DATA_INPUT,
		CMD_DATA_OUTPUT
	} io_cmd_t;

	typedef struct packed {
		logic       main_hit;
		logic       stat_hit;
		logic       legal;
		io_cmd_t    cmd;
	} io_req_t;

	typedef struct packed {
		logic              mode;
		logic              busy;
		logic              done;
		logic [CHAN_W-1:0] chan;
	} ctrl_t;

endpackage

// ==== src/io_cmd_decode.sv ====
// Decodes an APB address into device number hit and I/O command.
// Assumes paddr holds the device number above the two command bits.
`timescale 1ns/1ps
module io_cmd_decode (
	input  wire logic [tape_punch_pkg::ADDR_W-1:0] i_paddr,  // APB address
	input  wire logic                              i_pwrite, // APB direction
	output tape_punch_pkg::io_req_t                o_req     // Decoded request
);
	logic [tape_punch_pkg::DEV_W-1:0] dev_num;
	tape_punch_pkg::io_cmd_t           cmd;
	logic                              dir_ok;

	always_comb begin
		dev_num = i_paddr[tape_punch_pkg::DEV_LSB +: tape_punch_pkg::DEV_W];
		cmd     = tape_punch_pkg::io_cmd_t'(i_paddr[tape_punch_pkg::CMD_LSB +: 2]);
		dir_ok  = i_pwrite == (cmd == tape_punch_pkg::CMD_LOAD_CONTROL ||
			cmd == tape_punch_pkg::CMD_DATA_OUTPUT);
		o_req.cmd      = cmd;
		o_req.main_hit = dev_num == tape_punch_pkg::PUNCH_DEV_NUM;
		o_req.stat_hit = dev_num == tape_punch_pkg::STATUS_DEV_NUM;
		// Status number only answers a conditions read
		o_req.legal    = dir_ok && (o_req.main_hit || (o_req.stat_hit &&
			cmd == tape_punch_pkg::CMD_READ_CONDITIONS));
	end
endmodule // io_cmd_decode

// ==== src/punch_timer.sv ====
// One-shot down counter with a single-cycle expiry pulse.
// Assumes i_limit is at least one; start restarts a running count.
`timescale 1ns/1ps
module punch_timer (
	input  wire logic                             i_mclk,    // System clock
	input  wire logic                             i_rst,     // Async reset, high
	input  wire logic                             i_start,   // Load and run
	input  wire logic                             i_stop,    // Abandon count
	input  wire logic [tape_punch_pkg::TMR_W-1:0] i_limit,   // Cycles to expiry
	output logic                                  o_running, // Counting
	output logic                                  o_expire   // Expiry pulse
);
	logic [tape_punch_pkg::TMR_W-1:0] count_ff;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			count_ff  <= 27'h0000000;
			o_running <= 1'b0;
			o_expire  <= 1'b0;
		end else if (i_start) begin
			count_ff  <= i_limit;
			o_running <= 1'b1;
			o_expire  <= 1'b0;
		end else if (i_stop) begin
			o_running <= 1'b0;
			o_expire  <= 1'b0;
		end else if (o_running) begin
			count_ff  <= count_ff - 27'h0000001;
			o_running <= count_ff != 27'h0000001;
			o_expire  <= count_ff == 27'h0000001;
		end else begin
			o_expire  <= 1'b0;
		end
	end
endmodule // punch_timer

// ==== src/tape_punch_unit.sv ====
// Paper tape punch controller on the shared I/O bus, reached over APB.
// Assumes one APB master; device number and command travel in the address.
`timescale 1ns/1ps
module tape_punch_unit #(
	parameter logic [tape_punch_pkg::TMR_W-1:0] SPINUP_CYCLES = tape_punch_pkg::SPINUP_CYC,
	parameter logic [tape_punch_pkg::TMR_W-1:0] IDLE_CYCLES   = tape_punch_pkg::IDLE_CYC,
	parameter logic [tape_punch_pkg::TMR_W-1:0] LINE_CYCLES   = tape_punch_pkg::LINE_CYC
) (
	input  wire logic                                 I_MCLK,         // 25 MHz clock
	input  wire logic                                 I_SYS_RST,      // Async reset
	input  wire logic                                 I_PSEL,         // APB select
	input  wire logic                                 I_PENABLE,      // APB enable
	input  wire logic                                 I_PWRITE,       // APB write
	input  wire logic [tape_punch_pkg::ADDR_W-1:0]    I_PADDR,        // Device, cmd
	input  wire logic [tape_punch_pkg::DATA_W-1:0]    I_PWDATA,       // Write data
	output logic      [tape_punch_pkg::DATA_W-1:0]    O_PRDATA,       // Read data
	output logic                                      O_PREADY,       // APB ready
	output logic                                      O_PSLVERR,      // APB error
	output logic      [tape_punch_pkg::PDATA_W-1:0]   O_PUNCH_HOLES,  // Hole pattern
	output logic                                      O_PUNCH_STROBE, // Punch pulse
	output logic                                      O_MOTOR_ON,     // Motor drive
	output logic      [tape_punch_pkg::NUM_CHAN-1:0]  O_PI_REQ        // Channels 1..7
);
	typedef enum logic [1:0] {
		MOTOR_OFF,
		MOTOR_SPINUP,
		MOTOR_RUN
	} motor_state_t;

	tape_punch_pkg::io_req_t              req;
	tape_punch_pkg::ctrl_t                ctrl_ff;
	motor_state_t                         motor_ff;
	logic [tape_punch_pkg::PDATA_W-1:0]   data_ff;
	logic                                 pending_ff;
	logic                                 punching_ff;
	logic                                 access;
	logic                                 acc;
	logic                                 load_wr;
	logic                                 out_wr;
	logic                                 busy_set_evt;
	logic                                 motor_start;
	logic                                 punch_start;
	logic                                 spin_expire;
	logic                                 idle_expire;
	logic                                 line_expire;
	logic [tape_punch_pkg::DATA_W-1:0]    nxt_rdata;
	logic [tape_punch_pkg::DATA_W-1:0]    status_word;
	logic [tape_punch_pkg::DATA_W-1:0]    cond_word;

	io_cmd_decode u_decode (
		.i_paddr  (I_PADDR),
		.i_pwrite (I_PWRITE),
		.o_req    (req)
	);

	// Bus handshake: one wait state, commit at the ready edge
	assign access   = I_PSEL && I_PENABLE && !O_PREADY;
	assign acc      = I_PSEL && I_PENABLE && O_PREADY && req.legal;
	assign load_wr  = acc && req.main_hit && req.cmd == tape_punch_pkg::CMD_LOAD_CONTROL;
	assign out_wr   = acc && req.main_hit && req.cmd == tape_punch_pkg::CMD_DATA_OUTPUT;

	assign busy_set_evt = out_wr || (load_wr && I_PWDATA[tape_punch_pkg::BUSY_BIT]);
	assign motor_start  = motor_ff == MOTOR_OFF && busy_set_evt;
	assign punch_start  = pending_ff && motor_ff == MOTOR_RUN && !punching_ff;

	always_comb begin
		cond_word = '0;
		cond_word[tape_punch_pkg::CHAN_LSB +: tape_punch_pkg::CHAN_W] = ctrl_ff.chan;
		cond_word[tape_punch_pkg::DONE_BIT] = ctrl_ff.done;
		cond_word[tape_punch_pkg::BUSY_BIT] = ctrl_ff.busy;
		cond_word[tape_punch_pkg::MODE_BIT] = ctrl_ff.mode;
		status_word = '0;
		status_word[tape_punch_pkg::ST_MOTOR_ON]    = motor_ff != MOTOR_OFF;
		status_word[tape_punch_pkg::ST_MOTOR_READY] = motor_ff == MOTOR_RUN;
		status_word[tape_punch_pkg::ST_PUNCHING]    = punching_ff;
	end

	always_comb begin
		nxt_rdata = '0;
		if (req.legal && req.stat_hit) begin
			nxt_rdata = status_word;
		end else if (req.legal && req.cmd == tape_punch_pkg::CMD_READ_CONDITIONS) begin
			nxt_rdata = cond_word;
		end else if (req.legal && req.cmd == tape_punch_pkg::CMD_DATA_INPUT) begin
			nxt_rdata[tape_punch_pkg::PDATA_W-1:0] = data_ff;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= 32'h00000000;
		end else begin
			O_PREADY  <= access;
			O_PSLVERR <= access && !req.legal;
			// Data lines stay quiet unless number and command both match
			O_PRDATA  <= access ? nxt_rdata : 32'h00000000;
		end
	end

	// Control register: done set by hardware wins over any clear
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctrl_ff <= '0;
		end else begin
			if (load_wr) begin
				ctrl_ff.chan <= I_PWDATA[tape_punch_pkg::CHAN_LSB +: tape_punch_pkg::CHAN_W];
				ctrl_ff.mode <= I_PWDATA[tape_punch_pkg::MODE_BIT];
			end
			if (line_expire) begin
				ctrl_ff.done <= 1'b1;
			end else if (out_wr) begin
				ctrl_ff.done <= 1'b0;
			end else if (load_wr) begin
				ctrl_ff.done <= I_PWDATA[tape_punch_pkg::DONE_BIT];
			end
			if (out_wr) begin
				ctrl_ff.busy <= 1'b1;
			end else if (line_expire) begin
				ctrl_ff.busy <= 1'b0;
			end else if (load_wr) begin
				ctrl_ff.busy <= I_PWDATA[tape_punch_pkg::BUSY_BIT];
			end
		end
	end

	// Data register and pending line
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			data_ff    <= 8'h00;
			pending_ff <= 1'b0;
		end else begin
			if (out_wr) begin
				data_ff <= I_PWDATA[tape_punch_pkg::PDATA_W-1:0];
			end
			if (out_wr) begin
				pending_ff <= 1'b1;
			end else if (punch_start) begin
				pending_ff <= 1'b0;
			end
		end
	end

	// Motor sequencing
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			motor_ff <= MOTOR_OFF;
		end else begin
			case (motor_ff)
				MOTOR_OFF: begin
					if (motor_start) begin
						motor_ff <= MOTOR_SPINUP;
					end
				end
				MOTOR_SPINUP: begin
					if (spin_expire) begin
						motor_ff <= MOTOR_RUN;
					end
				end
				MOTOR_RUN: begin
					if (idle_expire && !punching_ff) begin
						motor_ff <= MOTOR_OFF;
					end
				end
				default: begin
					motor_ff <= MOTOR_OFF;
				end
			endcase
		end
	end

	punch_timer u_spin_tmr (
		.i_mclk    (I_MCLK),
		.i_rst     (I_SYS_RST),
		.i_start   (motor_start),
		.i_stop    (1'b0),
		.i_limit   (SPINUP_CYCLES),
		.o_running (),
		.o_expire  (spin_expire)
	);

	punch_timer u_idle_tmr (
		.i_mclk    (I_MCLK),
		.i_rst     (I_SYS_RST),
		.i_start   (motor_start || out_wr),
		.i_stop    (1'b0),
		.i_limit   (IDLE_CYCLES),
		.o_running (),
		.o_expire  (idle_expire)
	);

	punch_timer u_line_tmr (
		.i_mclk    (I_MCLK),
		.i_rst     (I_SYS_RST),
		.i_start   (punch_start),
		.i_stop    (1'b0),
		.i_limit   (LINE_CYCLES),
		.o_running (),
		.o_expire  (line_expire)
	);

	// Punch head drive
	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_PUNCH_HOLES  <= 8'h00;
			O_PUNCH_STROBE <= 1'b0;
			punching_ff    <= 1'b0;
		end else begin
			O_PUNCH_STROBE <= punch_start;
			if (punch_start) begin
				punching_ff <= 1'b1;
				if (ctrl_ff.mode) begin
					O_PUNCH_HOLES <= {1'b1, 1'b0, data_ff[tape_punch_pkg::BIN_W-1:0]};
				end else begin
					O_PUNCH_HOLES <= data_ff;
				end
			end else if (line_expire) begin
				punching_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_MOTOR_ON <= 1'b0;
		end else begin
			O_MOTOR_ON <= motor_ff != MOTOR_OFF;
		end
	end

	// One request line per channel, done is the service condition
	for (genvar ch = 0; ch < tape_punch_pkg::NUM_CHAN; ch++) begin : g_pi
		always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
			if (I_SYS_RST) begin
				O_PI_REQ[ch] <= 1'b0;
			end else begin
				O_PI_REQ[ch] <= ctrl_ff.done &&
					ctrl_ff.chan == tape_punch_pkg::CHAN_W'(ch + 1);
			end
		end
	end

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_SYS_RST);

	rdata_quiet_a: assert property (
		(O_PREADY && !$past(req.legal)) |-> O_PRDATA == 32'h00000000)
		else $error("read data driven without a matching request");

	chan_load_a: assert property (
		load_wr |=> ctrl_ff.chan == $past(I_PWDATA[2:0]))
		else $error("channel field not loaded by load control");

	pi_onehot_a: assert property (
		(ctrl_ff.done && ctrl_ff.chan != 3'h0) |=> O_PI_REQ[$past(ctrl_ff.chan) - 3'h1])
		else $error("request missing on assigned channel");

	pi_none_a: assert property (
		(ctrl_ff.chan == 3'h0 || !ctrl_ff.done) |=> O_PI_REQ == 7'h00)
		else $error("request raised while disconnected or not done");

	alpha_holes_a: assert property (
		(punch_start && !ctrl_ff.mode) |=> O_PUNCH_HOLES == $past(data_ff) && O_PUNCH_STROBE)
		else $error("alpha pattern wrong");

	binary_holes_a: assert property (
		(punch_start && ctrl_ff.mode) |=> O_PUNCH_HOLES[7] && !O_PUNCH_HOLES[6]
			&& O_PUNCH_HOLES[5:0] == $past(data_ff[5:0]))
		else $error("binary pattern wrong");

	data_low_a: assert property (
		out_wr |=> data_ff == $past(I_PWDATA[7:0]) && pending_ff)
		else $error("data register not loaded from low byte");

	out_flags_a: assert property (
		(out_wr && !line_expire) |=> ctrl_ff.busy && !ctrl_ff.done)
		else $error("data output did not set busy and clear done");

	spinup_hold_a: assert property (
		motor_start |=> (punching_ff == 1'b0 && motor_ff == MOTOR_SPINUP) [*8])
		else $error("punching during spin-up");

	run_gate_a: assert property (
		$rose(motor_ff == MOTOR_RUN) |-> $past(spin_expire))
		else $error("motor ready before spin-up expired");

	line_done_a: assert property (
		(line_expire && !out_wr && !load_wr) |=> ctrl_ff.done && !ctrl_ff.busy && !punching_ff)
		else $error("line completion flags wrong");

	cond_read_a: assert property (
		(O_PREADY && $past(req.legal && req.main_hit
			&& req.cmd == tape_punch_pkg::CMD_READ_CONDITIONS))
		|-> O_PRDATA[5:0] == $past({ctrl_ff.mode, ctrl_ff.busy, ctrl_ff.done, ctrl_ff.chan}))
		else $error("conditions read data wrong");

	// Bus answers and refusals, mode load
	err_quiet_a: assert property (
		O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h00000000)
		else $error("error answer carried read data");

	illegal_ignored_a: assert property (
		(I_PSEL && I_PENABLE && O_PREADY && !req.legal && !line_expire)
		|=> $stable(ctrl_ff) && $stable(data_ff))
		else $error("refused command changed device state");

	data_read_a: assert property (
		(O_PREADY && $past(req.legal && req.main_hit
			&& req.cmd == tape_punch_pkg::CMD_DATA_INPUT))
		|-> O_PRDATA == {24'h000000, $past(data_ff)})
		else $error("data read not on low lines");

	status_read_a: assert property (
		(O_PREADY && $past(req.legal && req.stat_hit))
		|-> O_PRDATA == {29'h00000000, $past(punching_ff), $past(motor_ff == MOTOR_RUN),
			$past(motor_ff != MOTOR_OFF)})
		else $error("status read data wrong");

	mode_load_a: assert property (
		load_wr |=> ctrl_ff.mode == $past(I_PWDATA[tape_punch_pkg::MODE_BIT]))
		else $error("mode bit not loaded by load control");

	// Motor and punch sequencing, single request line
	busy_start_a: assert property (
		(busy_set_evt && motor_ff == MOTOR_OFF) |=> motor_ff == MOTOR_SPINUP)
		else $error("setting busy did not start the motor");

	hold_line_a: assert property (
		(pending_ff && motor_ff != MOTOR_RUN) |=> pending_ff && !O_PUNCH_STROBE)
		else $error("line punched before motor reached speed");

	idle_stop_a: assert property (
		(motor_ff == MOTOR_RUN && idle_expire && !punching_ff) |=> motor_ff == MOTOR_OFF)
		else $error("motor kept running after idle time");

	motor_pin_a: assert property (
		O_MOTOR_ON == $past(motor_ff != MOTOR_OFF))
		else $error("motor drive does not follow motor state");

	pi_single_a: assert property (
		$onehot0(O_PI_REQ))
		else $error("request raised on more than one channel");

	line_punched_c: cover property (punch_start ##[1:1000] line_expire);
	binary_punch_c: cover property (punch_start && ctrl_ff.mode);
	idle_off_c:     cover property (motor_ff == MOTOR_RUN && idle_expire);
	status_read_c:  cover property (O_PREADY && $past(req.stat_hit && req.legal));
	refused_c:      cover property (O_PSLVERR);

endmodule // tape_punch_unit

// ==== verif/io_processor_model.sv ====
// Processor side of the I/O bus: an APB master issuing device commands.
// Assumes one caller at a time and a free-running clock.
`timescale 1ns/1ps
module io_processor_model (
	input  wire logic        i_mclk,    // System clock
	input  wire logic [31:0] i_prdata,  // Read data
	input  wire logic        i_pready,  // Ready
	input  wire logic        i_pslverr, // Error
	input  wire logic [6:0]  i_pi_req,  // Channel requests
	output logic             o_psel,    // Select
	output logic             o_penable, // Enable
	output logic             o_pwrite,  // Direction
	output logic [10:0]      o_paddr,   // Device and command
	output logic [2:0]       o_grant,   // Granted channel, 0 none
	output logic [31:0]      o_pwdata   // Write data
);
	initial begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 11'h000;
		o_pwdata  = 32'h0;
	end

	// Grant goes to the lowest-numbered requesting channel
	always_comb begin
		o_grant = 3'h0;
		for (int ch = 6; ch >= 0; ch--) begin
			if (i_pi_req[ch]) o_grant = 3'(ch + 1);
		end
	end

	task automatic xfer(input logic w, input logic [6:0] dev, input logic [1:0] cmd,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge i_mclk);
		o_psel    <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite  <= w;
		o_paddr   <= {dev, cmd, 2'h0};
		o_pwdata  <= wd;
		@(posedge i_mclk);
		o_penable <= 1'b1;
		do @(posedge i_mclk); while (i_pready !== 1'b1);
		rd = i_prdata;
		err = i_pslverr;
		// Released lines must not keep showing the old value
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
		o_paddr   <= ~{dev, cmd, 2'h0};
		o_pwdata  <= ~wd;
	endtask
endmodule // io_processor_model

// ==== verif/testbench.sv ====
// Self-checking bench for the tape punch unit behind a processor model.
// Assumes shortened spin-up, idle and line times given below.
`timescale 1ns/1ps
module testbench;
	localparam int         SPIN = 20;
	localparam int         IDLE = 200;
	localparam int         LINE = 10;
	localparam logic [6:0] DEV  = tape_punch_pkg::PUNCH_DEV_NUM;
	localparam logic [6:0] STA  = tape_punch_pkg::STATUS_DEV_NUM;
	localparam logic [1:0] LC   = tape_punch_pkg::CMD_LOAD_CONTROL;
	localparam logic [1:0] RC   = tape_punch_pkg::CMD_READ_CONDITIONS;
	localparam logic [1:0] DI   = tape_punch_pkg::CMD_DATA_INPUT;
	localparam logic [1:0] DO   = tape_punch_pkg::CMD_DATA_OUTPUT;

	logic        mclk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [10:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  holes;
	logic        strobe;
	logic        motor;
	logic [6:0]  pi_req;
	logic [2:0]  grant;
	logic [7:0]  holes_seen;
	int          cyc;
	int          t_motor;
	int          t_strobe;
	int          t_out;
	int          n_strobe;
	int          failures;
	int          total_checks;

	io_processor_model proc (
		.i_mclk(mclk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata), .i_pi_req(pi_req), .o_grant(grant)
	);

	tape_punch_unit #(
		.SPINUP_CYCLES(27'(SPIN)), .IDLE_CYCLES(27'(IDLE)), .LINE_CYCLES(27'(LINE))
	) tape_punch_unit_inst (
		.I_MCLK(mclk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .O_PUNCH_HOLES(holes),
		.O_PUNCH_STROBE(strobe), .O_MOTOR_ON(motor), .O_PI_REQ(pi_req)
	);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		cyc = 0;
		t_motor = 0;
		t_strobe = 0;
		n_strobe = 0;
		failures = 0;
		total_checks = 0;
		holes_seen = 8'h00;
	end

	// Punch watcher and run limit
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (strobe === 1'b1) begin
			holes_seen <= holes;
			n_strobe <= n_strobe + 1;
			if (n_strobe == 0) t_strobe <= cyc;
		end
		if (motor === 1'b1 && t_motor == 0) t_motor <= cyc;
		if (cyc == 3000) begin
			failures++;
			wrap_up;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic op(input logic w, input logic [6:0] dev, input logic [1:0] cmd,
		input logic [31:0] wd, input logic [31:0] exp, input logic err_exp);
		logic [31:0] d;
		logic        e;
		proc.xfer(w, dev, cmd, wd, d, e);
		check(d, exp);
		check({31'h0, e}, {31'h0, err_exp});
	endtask

	task automatic wait_done;
		logic [31:0] d;
		logic        e;
		int          n;
		d = 32'h0;
		n = 0;
		while (d[3] !== 1'b1 && n < 50) begin
			proc.xfer(1'b0, DEV, RC, 32'h0, d, e);
			n++;
		end
	endtask

	task automatic wrap_up;
		$display("Checks: %0d, failures: %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		op(1'b0, DEV, RC, 32'h0, 32'h0, 1'b0);
		op(1'b0, STA, RC, 32'h0, 32'h0, 1'b0);
		check({25'h0, pi_req}, 32'h0);
		op(1'b1, 7'h42, LC, 32'h3F, 32'h0, 1'b1);
		op(1'b0, 7'h42, RC, 32'h0, 32'h0, 1'b1);
		op(1'b1, DEV, RC, 32'h3F, 32'h0, 1'b1);
		op(1'b0, STA, DI, 32'h0, 32'h0, 1'b1);
		op(1'b0, DEV, RC, 32'h0, 32'h0, 1'b0);
		check({31'h0, motor}, 32'h0);
		op(1'b1, DEV, LC, 32'h11, 32'h0, 1'b0);
		op(1'b0, DEV, RC, 32'h0, 32'h11, 1'b0);
		op(1'b0, STA, RC, 32'h0, 32'h1, 1'b0);
		op(1'b1, DEV, DO, 32'h1A5, 32'h0, 1'b0);
		op(1'b0, DEV, DI, 32'h0, 32'hA5, 1'b0);
		op(1'b0, DEV, RC, 32'h0, 32'h11, 1'b0);
		wait_done;
		check({24'h0, holes_seen}, 32'hA5);
		op(1'b0, DEV, RC, 32'h0, 32'h09, 1'b0);
		check({25'h0, pi_req}, 32'h01);
		check({29'h0, grant}, 32'h1);
		check({31'h0, t_strobe - t_motor >= SPIN}, 32'h1);
		check({31'h0, t_strobe - t_motor <= SPIN + 8}, 32'h1);
		op(1'b0, STA, RC, 32'h0, 32'h3, 1'b0);
		// Binary mode, channel 3, flags cleared
		op(1'b1, DEV, LC, 32'h23, 32'h0, 1'b0);
		op(1'b0, DEV, RC, 32'h0, 32'h23, 1'b0);
		check({25'h0, pi_req}, 32'h0);
		op(1'b1, DEV, DO, 32'hFF, 32'h0, 1'b0);
		op(1'b0, DEV, RC, 32'h0, 32'h33, 1'b0);
		wait_done;
		check({24'h0, holes_seen}, 32'hBF);
		check({25'h0, pi_req}, 32'h04);
		check({29'h0, grant}, 32'h3);
		// Channel zero leaves a set done unconnected
		op(1'b1, DEV, LC, 32'h28, 32'h0, 1'b0);
		repeat (3) @(posedge mclk);
		check({25'h0, pi_req}, 32'h0);
		check({29'h0, grant}, 32'h0);
		op(1'b1, DEV, DO, 32'h40, 32'h0, 1'b0);
		t_out = cyc;
		wait_done;
		check({24'h0, holes_seen}, 32'h80);
		check(n_strobe, 32'h3);
		while (cyc < t_out + IDLE - 10) @(posedge mclk);
		check({31'h0, motor}, 32'h1);
		while (cyc < t_out + IDLE + 10) @(posedge mclk);
		check({31'h0, motor}, 32'h0);
		op(1'b0, STA, RC, 32'h0, 32'h0, 1'b0);
		wrap_up;
	end
endmodule // testbench
